// [design/bus_if.sv]
// Conditioned bus events passed from the line front end to the engine
`timescale 1ns/1ns
interface bus_if;
	logic scl_rise;
	logic scl_fall;
	logic start_seen;
	logic stop_seen;
	logic sda_level;
	modport source (output scl_rise, scl_fall, start_seen, stop_seen,
		sda_level);
	modport sink (input scl_rise, scl_fall, start_seen, stop_seen,
		sda_level);
endinterface

// [design/line_sampler.sv]
// Synchronises the bus lines and finds clock edges and start/stop
`timescale 1ns/1ns
module line_sampler (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic scl_i,
	input wire logic sda_i,
	bus_if.source ev
);
	import nvram_pkg::*;
	logic [1:0] scl_sync_reg, scl_sync_next;
	logic [1:0] sda_sync_reg, sda_sync_next;
	logic scl_old_reg, scl_old_next;
	logic sda_old_reg, sda_old_next;

	always_comb begin
		scl_sync_next = {scl_sync_reg[0], scl_i};
		sda_sync_next = {sda_sync_reg[0], sda_i};
		scl_old_next = scl_sync_reg[1];
		sda_old_next = sda_sync_reg[1];
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			scl_sync_reg <= 2'h3;
			sda_sync_reg <= 2'h3;
			scl_old_reg <= 1'b1;
			sda_old_reg <= 1'b1;
		end else begin
			scl_sync_reg <= scl_sync_next;
			sda_sync_reg <= sda_sync_next;
			scl_old_reg <= scl_old_next;
			sda_old_reg <= sda_old_next;
		end
	end

	// Only the second stage and its delayed copy feed the detectors
	assign ev.scl_rise = scl_sync_reg[1] & ~scl_old_reg;
	assign ev.scl_fall = ~scl_sync_reg[1] & scl_old_reg;
	// falling data while clock stays high
	assign ev.start_seen = scl_sync_reg[1] & scl_old_reg & sda_old_reg
		& ~sda_sync_reg[1];
	// rising data while clock stays high
	assign ev.stop_seen = scl_sync_reg[1] & scl_old_reg & ~sda_old_reg
		& sda_sync_reg[1];
	assign ev.sda_level = sda_sync_reg[1];

	start_stop_excl_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		!(ev.start_seen && ev.stop_seen))
		else $error("start and stop flagged together");
endmodule

// [design/nvram_pkg.sv]
// Shared constants and types for the two-wire memory slave
package nvram_pkg;
	localparam int ADDR_W = 16;
	localparam int DEPTH = 65536;
	localparam int STRAP_W = 3;
	localparam int SYNC_STAGES = 2;
	// Type code value is arbitrary
	localparam logic [3:0] TYPE_CODE_DEFAULT = 4'h5;
	localparam logic [3:0] BIT_CNT_RESET = 4'h0;
	localparam logic [3:0] BIT_CNT_ACK = 4'h8;
	localparam logic [ADDR_W-1:0] ADDR_RESET = 16'h0000;
	localparam logic [7:0] BYTE_RESET = 8'h00;

	typedef enum logic [6:0] {
		ST_IDLE = 7'b0000001,
		ST_DEVADR = 7'b0000010,
		ST_ADRHI = 7'b0000100,
		ST_ADRLO = 7'b0001000,
		ST_WDATA = 7'b0010000,
		ST_RDATA = 7'b0100000,
		ST_RACK = 7'b1000000
	} slave_state_t;
endpackage

// [design/nvram_slave.sv]
// Two-wire slave front end with 64K x 8 byte store
//
// Contract
// - Up to eight devices share bus via straps
// - Act only when address code matches straps
// - Open strap inputs read as low (code: low only from reset, then follows the pins)
// - Data line driven open-drain only
// - Sample on clock rise, change after fall
// - Write-protect high blocks all memory writes
// - Reads allowed at any write-protect level
// - Open write-protect reads as low, writable (code: low only from reset, then follows the pin)
// - Device is slave, never drives clock
// - Data changes only while clock low
// - Data fall with clock high starts transfer
// - Data rise with clock high stops, standby
// - Ready immediately after write stop
// - Receiver pulls data low on ninth clock
// - Transmitter releases data on acknowledge clock
// - Stop before acknowledge aborts to standby
// - Release bus after not-acknowledge
// - Address word: type, strap code, direction
// - Upper four bits match fixed type code
// - 65,536 individually addressed byte locations
// - Direction bit zero writes, one reads
// - Mismatch keeps standby, no acknowledge
// - Two address bytes, high first, acknowledged
// - Address increments and wraps to zero
`timescale 1ns/1ns
module nvram_slave #(
	parameter logic [3:0] TYPE_CODE = nvram_pkg::TYPE_CODE_DEFAULT
) (
	input wire logic CLK_I,
	input wire logic RST_I,
	input wire logic SCL_I,
	input wire logic SDA_I,
	output logic SDA_O,
	output logic SDA_OE_O,
	input wire logic [nvram_pkg::STRAP_W-1:0] STRAP_I,
	input wire logic WP_I,
	output logic BUSY_O
);
	import nvram_pkg::*;

	initial begin
		if (DEPTH != (1 << ADDR_W))
			$error("depth must equal two to the address width");
	end

	bus_if ev();
	logic [2:0] strap;
	logic wp;

	line_sampler u_line (
		.clk_i(CLK_I),
		.rst_i(RST_I),
		.scl_i(SCL_I),
		.sda_i(SDA_I),
		.ev(ev)
	);

	strap_latch u_strap (
		.clk_i(CLK_I),
		.rst_i(RST_I),
		.strap_i(STRAP_I),
		.wp_i(WP_I),
		.strap_o(strap),
		.wp_o(wp)
	);

	// byte store; no reset, contents persist
	logic [7:0] mem [0:DEPTH-1];

	slave_state_t state_reg, state_next;
	logic [3:0] bit_reg, bit_next;
	logic [7:0] shift_reg, shift_next;
	logic [ADDR_W-1:0] addr_reg, addr_next;
	logic [7:0] hi_reg, hi_next;
	logic drive_reg, drive_next;
	logic busy_reg, busy_next;
	logic wr_en;
	logic [7:0] rd_byte;
	logic [2:0] rd_idx;

	function automatic logic addr_match(input logic [7:0] w,
		input logic [2:0] s, input logic [3:0] t);
		addr_match = (w[7:4] == t) && (w[3:1] == s);
	endfunction

	assign rd_byte = mem[addr_reg];
	assign rd_idx = 3'h7 - bit_reg[2:0];

	always_comb begin
		state_next = state_reg;
		bit_next = bit_reg;
		shift_next = shift_reg;
		addr_next = addr_reg;
		hi_next = hi_reg;
		drive_next = drive_reg;
		busy_next = (state_reg != ST_IDLE);
		wr_en = 1'b0;
		if (ev.stop_seen) begin
			state_next = ST_IDLE;
			drive_next = 1'b0;
			bit_next = BIT_CNT_RESET;
		end else if (ev.start_seen) begin
			state_next = ST_DEVADR;
			drive_next = 1'b0;
			bit_next = BIT_CNT_RESET;
		end else if (state_reg != ST_IDLE && ev.scl_rise) begin
			if (bit_reg < BIT_CNT_ACK) begin
				shift_next = {shift_reg[6:0], ev.sda_level};
				bit_next = bit_reg + 4'h1;
			end else if (state_reg == ST_RACK && ev.sda_level) begin
				state_next = ST_IDLE; // master not-acknowledged
			end
		end else if (state_reg != ST_IDLE && ev.scl_fall) begin
			// output changes only after falling clock
			if (bit_reg == BIT_CNT_ACK) begin
				// Eighth bit just ended: acknowledge slot begins
				drive_next = 1'b0;
				case (state_reg)
					ST_DEVADR: begin
						if (addr_match(shift_reg, strap, TYPE_CODE)) begin
							drive_next = 1'b1;
							state_next = shift_reg[0] ? ST_RACK
								: ST_ADRHI;
						end else begin
							state_next = ST_IDLE;
						end
					end
					ST_ADRHI: begin
						hi_next = shift_reg;
						drive_next = 1'b1;
						state_next = ST_ADRLO;
					end
					ST_ADRLO: begin
						addr_next = {hi_reg, shift_reg};
						drive_next = 1'b1;
						state_next = ST_WDATA;
					end
					ST_WDATA: begin
						wr_en = ~wp;
						addr_next = addr_reg + 16'h0001;
						drive_next = 1'b1;
					end
					ST_RDATA: begin
						state_next = ST_RACK; // released for master
						addr_next = addr_reg + 16'h0001;
					end
					default: begin
						state_next = state_reg;
					end
				endcase
				// Ninth clock follows in every state, read ack included
				bit_next = 4'h9;
			end else if (bit_reg == 4'h9) begin
				// Ninth clock over: release acknowledge
				drive_next = 1'b0;
				bit_next = BIT_CNT_RESET;
			end else if (state_reg == ST_RDATA) begin
				// open-drain: pull low for a zero bit
				drive_next = ~rd_byte[rd_idx];
			end
		end
		// Read acknowledge slot closes: load first bit of next byte
		if (!ev.stop_seen && !ev.start_seen && ev.scl_fall
			&& state_reg == ST_RACK && bit_reg == 4'h9) begin
			state_next = ST_RDATA;
			bit_next = BIT_CNT_RESET;
			drive_next = ~rd_byte[7];
		end
	end

	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			state_reg <= ST_IDLE;
			bit_reg <= BIT_CNT_RESET;
			shift_reg <= BYTE_RESET;
			addr_reg <= ADDR_RESET;
			hi_reg <= BYTE_RESET;
			drive_reg <= 1'b0;
			busy_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			bit_reg <= bit_next;
			shift_reg <= shift_next;
			addr_reg <= addr_next;
			hi_reg <= hi_next;
			drive_reg <= drive_next;
			busy_reg <= busy_next;
		end
	end

	always_ff @(posedge CLK_I) begin
		if (wr_en)
			mem[addr_reg] <= shift_reg;
	end

	// data pin only pulls low; no clock output exists
	assign SDA_O = 1'b0;
	assign SDA_OE_O = drive_reg;
	assign BUSY_O = busy_reg;

	// Checks: byte_end marks the falling clock that opens an ack slot
	logic quiet;
	logic byte_end;
	assign quiet = !ev.stop_seen && !ev.start_seen;
	assign byte_end = ev.scl_fall && bit_reg == BIT_CNT_ACK && quiet;

	wp_blocks_write_a: assert property (
		@(posedge CLK_I) disable iff (RST_I)
		wp |-> !wr_en)
		else $error("write while protected");
	write_slot_a: assert property (
		@(posedge CLK_I) disable iff (RST_I)
		wr_en |-> state_reg == ST_WDATA && byte_end)
		else $error("write outside data acknowledge");
	byte_kept_a: assert property (
		@(posedge CLK_I) disable iff (RST_I)
		state_reg == ST_WDATA && byte_end && wp
		|=> mem[$past(addr_reg)] == $past(rd_byte))
		else $error("protected byte changed");
	byte_stored_a: assert property (
		@(posedge CLK_I) disable iff (RST_I)
		state_reg == ST_WDATA && byte_end && !wp
		|=> mem[$past(addr_reg)] == $past(shift_reg))
		else $error("data byte not stored");

	// Framing: start and stop win over any bit in flight
	stop_to_idle_a: assert property (
		@(posedge CLK_I) disable iff (RST_I)
		ev.stop_seen |=> state_reg == ST_IDLE && !drive_reg)
		else $error("stop did not return to standby");
	start_to_addr_a: assert property (
		@(posedge CLK_I) disable iff (RST_I)
		ev.start_seen && !ev.stop_seen |=> state_reg == ST_DEVADR)
		else $error("start not taken");
	change_on_fall_a: assert property (
		@(posedge CLK_I) disable iff (RST_I)
		$changed(drive_reg) |-> $past(ev.scl_fall) || $past(ev.stop_seen)
		|| $past(ev.start_seen))
		else $error("data changed outside falling clock");
	busy_follows_a: assert property (
		@(posedge CLK_I) disable iff (RST_I)
		busy_reg == $past(state_reg != ST_IDLE))
		else $error("busy flag out of step with state");

	rise_shift_a: assert property (
		@(posedge CLK_I) disable iff (RST_I)
		state_reg != ST_IDLE && ev.scl_rise && bit_reg < BIT_CNT_ACK
		&& quiet
		|=> shift_reg == {$past(shift_reg[6:0]), $past(ev.sda_level)})
		else $error("bit not shifted in on rising clock");
	mismatch_no_ack_a: assert property (
		@(posedge CLK_I) disable iff (RST_I)
		state_reg == ST_DEVADR && byte_end
		&& !addr_match(shift_reg, strap, TYPE_CODE)
		|=> state_reg == ST_IDLE && !drive_reg)
		else $error("foreign address acknowledged");
	idle_released_a: assert property (
		@(posedge CLK_I) disable iff (RST_I)
		state_reg == ST_IDLE |-> !drive_reg)
		else $error("data line pulled in standby");
	match_ack_a: assert property (
		@(posedge CLK_I) disable iff (RST_I)
		state_reg == ST_DEVADR && byte_end
		&& addr_match(shift_reg, strap, TYPE_CODE) |=> drive_reg)
		else $error("own address not acknowledged");

	dir_write_a: assert property (
		@(posedge CLK_I) disable iff (RST_I)
		state_reg == ST_DEVADR && byte_end && !shift_reg[0]
		&& addr_match(shift_reg, strap, TYPE_CODE)
		|=> state_reg == ST_ADRHI)
		else $error("write direction not taken");
	dir_read_a: assert property (
		@(posedge CLK_I) disable iff (RST_I)
		state_reg == ST_DEVADR && byte_end && shift_reg[0]
		&& addr_match(shift_reg, strap, TYPE_CODE)
		|=> state_reg == ST_RACK && bit_reg == 4'h9)
		else $error("read direction not taken");
	hi_load_a: assert property (
		@(posedge CLK_I) disable iff (RST_I)
		state_reg == ST_ADRHI && byte_end
		|=> hi_reg == $past(shift_reg) && state_reg == ST_ADRLO
		&& drive_reg)
		else $error("high address byte not taken");
	addr_load_a: assert property (
		@(posedge CLK_I) disable iff (RST_I)
		state_reg == ST_ADRLO && byte_end
		|=> addr_reg == {$past(hi_reg), $past(shift_reg)}
		&& state_reg == ST_WDATA && drive_reg)
		else $error("memory address not loaded");

	// Receiver side: the pull must cover the whole ninth clock
	ack_held_a: assert property (
		@(posedge CLK_I) disable iff (RST_I)
		bit_reg == 4'h9 && (state_reg == ST_ADRHI
		|| state_reg == ST_ADRLO || state_reg == ST_WDATA)
		|-> drive_reg)
		else $error("acknowledge not held through ninth clock");
	ack_slot_end_a: assert property (
		@(posedge CLK_I) disable iff (RST_I)
		state_reg != ST_IDLE && ev.scl_fall && bit_reg == 4'h9 && quiet
		|=> !drive_reg || state_reg == ST_RDATA)
		else $error("acknowledge not released after ninth clock");
	addr_wrap_a: assert property (
		@(posedge CLK_I) disable iff (RST_I)
		state_reg == ST_WDATA && byte_end && addr_reg == 16'hFFFF
		|=> addr_reg == 16'h0000)
		else $error("address did not wrap");

	// Transmitter side: the master answers on the ninth clock
	read_release_a: assert property (
		@(posedge CLK_I) disable iff (RST_I)
		state_reg == ST_RDATA && byte_end
		|=> state_reg == ST_RACK && !drive_reg && bit_reg == 4'h9)
		else $error("data line held in master acknowledge slot");
	read_next_a: assert property (
		@(posedge CLK_I) disable iff (RST_I)
		state_reg == ST_RDATA && byte_end
		|=> addr_reg == $past(addr_reg) + 16'h0001)
		else $error("read address not advanced");
	ack_msb_a: assert property (
		@(posedge CLK_I) disable iff (RST_I)
		state_reg == ST_RACK && ev.scl_fall && bit_reg == 4'h9 && quiet
		|=> state_reg == ST_RDATA && drive_reg == !$past(rd_byte[7]))
		else $error("first read bit not driven");
	read_bit_a: assert property (
		@(posedge CLK_I) disable iff (RST_I)
		state_reg == ST_RDATA && ev.scl_fall && bit_reg != 4'h0
		&& bit_reg < BIT_CNT_ACK && quiet
		|=> drive_reg == !$past(rd_byte[rd_idx]))
		else $error("read bit driven wrongly");
	nack_release_a: assert property (
		@(posedge CLK_I) disable iff (RST_I)
		state_reg == ST_RACK && ev.scl_rise && bit_reg == 4'h9
		&& ev.sda_level && quiet
		|=> state_reg == ST_IDLE ##1 !drive_reg)
		else $error("bus held after not-acknowledge");
endmodule

// [design/strap_latch.sv]
// Synchronises strap and write-protect levels
`timescale 1ns/1ns
module strap_latch (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [2:0] strap_i,
	input wire logic wp_i,
	output logic [2:0] strap_o,
	output logic wp_o
);
	import nvram_pkg::*;
	logic [3:0] s1_reg, s1_next;
	logic [3:0] s2_reg, s2_next;

	always_comb begin
		s1_next = {wp_i, strap_i};
		s2_next = s1_reg;
	end

	// Reset values are low; two clocks after reset straps and protect follow the pins as sampled
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			s1_reg <= 4'h0;
			s2_reg <= 4'h0;
		end else begin
			s1_reg <= s1_next;
			s2_reg <= s2_next;
		end
	end

	assign strap_o = s2_reg[2:0];
	assign wp_o = s2_reg[3];
endmodule

// [testbench/bus_master.sv]
// Behavioural two-wire bus master for the memory slave bench
`timescale 1ns/1ns
module bus_master (
	input wire logic clk_i,
	input wire logic sda_i,
	output logic scl_o,
	output logic pull_o
);
	initial begin
		scl_o = 1'b1;
		pull_o = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	// Clock rests high between frames; only this model moves it
	task automatic start();
		tick(4);
		pull_o = 1'b0;
		tick(4);
		scl_o = 1'b1;
		tick(8);
		pull_o = 1'b1;
		tick(8);
		scl_o = 1'b0;
	endtask
	task automatic stop();
		tick(4);
		pull_o = 1'b1;
		tick(4);
		scl_o = 1'b1;
		tick(8);
		pull_o = 1'b0;
		tick(8);
	endtask
	// Data moves mid-low so the slave's slow sampler holds it
	task automatic bit_x(input logic b, output logic r);
		tick(4);
		pull_o = !b;
		tick(4);
		scl_o = 1'b1;
		tick(4);
		r = sda_i;
		tick(4);
		scl_o = 1'b0;
	endtask
	// Eight bits MSB first, then the acknowledge clock
	task automatic xfer(input logic [7:0] d, input logic m,
		output logic [7:0] q, output logic a);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_x(d[i], r);
			q[i] = r;
		end
		bit_x(m, a);
	endtask
endmodule

// [testbench/i2c_nvram_slave_front_end_tb_top.sv]
// Self-checking bench for the two-wire memory slave
`timescale 1ns/1ns
module i2c_nvram_slave_front_end_tb_top;
	import nvram_pkg::*;
	logic clk, rst, scl, pull, wp, oe, sdo, busy, a;
	logic oe_q = 1'b0;
	logic [2:0] strap;
	logic [7:0] q;
	int err_count = 0;
	int n_checks = 0;
	int cyc = 0;
	// Pull-up on the data wire; either party may only pull it low
	wire logic sda = !(oe | pull);
	nvram_slave dut_u (.CLK_I(clk), .RST_I(rst), .SCL_I(scl), .SDA_I(sda),
		.SDA_O(sdo), .SDA_OE_O(oe), .STRAP_I(strap), .WP_I(wp),
		.BUSY_O(busy));
	bus_master mst_u (.clk_i(clk), .sda_i(sda), .scl_o(scl), .pull_o(pull));
	task automatic test_done();
		if (err_count == 0 && n_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp,
		input string m);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	function automatic logic [7:0] aw(input logic [2:0] s, input logic r);
		return {TYPE_CODE_DEFAULT, s, r};
	endfunction
	task automatic wb(input logic [7:0] d, input logic ea);
		mst_u.xfer(d, 1'b1, q, a);
		chk({7'h00, a}, {7'h00, ea}, "ack");
	endtask
	task automatic set_addr(input logic [15:0] ad);
		mst_u.start();
		wb(aw(strap, 1'b0), 1'b0);
		chk({7'h00, busy}, 8'h01, "busy in transfer");
		wb(ad[15:8], 1'b0);
		wb(ad[7:0], 1'b0);
	endtask
	task automatic write_mem(input logic [15:0] ad, input logic [7:0] d0,
		input logic [7:0] d1);
		set_addr(ad);
		wb(d0, 1'b0);
		wb(d1, 1'b0);
		mst_u.stop();
		chk({7'h00, busy}, 8'h00, "standby");
	endtask
	task automatic read_mem(input logic [15:0] ad, input logic [7:0] e0,
		input logic [7:0] e1);
		set_addr(ad);
		mst_u.start();
		wb(aw(strap, 1'b1), 1'b0);
		mst_u.xfer(8'hFF, 1'b0, q, a);
		chk(q, e0, "read byte 0");
		mst_u.xfer(8'hFF, 1'b1, q, a);
		chk(q, e1, "read byte 1");
		mst_u.stop();
		chk({7'h00, busy}, 8'h00, "standby");
	endtask
	task automatic t_basic();
		write_mem(16'h1234, 8'hA5, 8'h3C);
		read_mem(16'h1234, 8'hA5, 8'h3C);
	endtask
	task automatic t_protect();
		wp = 1'b1;
		write_mem(16'h1234, 8'h77, 8'h88);
		read_mem(16'h1234, 8'hA5, 8'h3C);
		wp = 1'b0;
	endtask
	task automatic t_wrap();
		// The store has no reset: fill what the wrap reads will reach
		write_mem(16'h0001, 8'h00, 8'h00);
		write_mem(16'hFFFF, 8'h11, 8'h22);
		read_mem(16'hFFFF, 8'h11, 8'h22);
		read_mem(16'h0000, 8'h22, 8'h00);
	endtask
	task automatic t_straps();
		for (int s = 0; s < 8; s++) begin
			strap = 3'(s);
			mst_u.start();
			wb(aw(strap, 1'b0), 1'b0);
			mst_u.stop();
			mst_u.start();
			wb(aw(strap ^ 3'h1, 1'b1), 1'b1);
			mst_u.stop();
			mst_u.start();
			wb({~TYPE_CODE_DEFAULT, strap, 1'b0}, 1'b1);
			mst_u.stop();
			chk({7'h00, busy}, 8'h00, "standby");
		end
	endtask
	task automatic t_abort();
		set_addr(16'h0000);
		for (int i = 0; i < 4; i++) mst_u.bit_x(1'b0, a);
		mst_u.stop();
		chk({7'h00, busy}, 8'h00, "abort");
		read_mem(16'h0000, 8'h22, 8'h00);
	endtask
	initial begin
		clk = 1'b0;
		forever #5 clk = !clk;
	end
	initial begin
		rst = 1'b1;
		wp = 1'b0;
		strap = 3'h5;
		repeat (3) @(posedge clk);
		#1;
		rst = 1'b0;
		repeat (3) @(posedge clk);
		#1;
		t_basic();
		t_protect();
		t_wrap();
		t_straps();
		t_abort();
		test_done();
	end
	// Watches the slave's drive enable and data pin; a count limit cuts a hung run short
	always @(posedge clk) begin
		cyc <= cyc + 1;
		oe_q <= oe;
		if (oe !== oe_q) chk({7'h00, scl}, 8'h00, "moved, clock high");
		if (oe === 1'b1) chk({7'h00, sdo}, 8'h00, "pin not open");
		if (cyc == 40000) begin
			err_count++;
			test_done();
		end
	end
endmodule
